// File: src/rtps_pkg.sv
/*
  Package for the one-hertz prescaler, trim and interrupt mask block.
  Assumes a single slow clock domain and a plain register port.
*/
package rtps_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] PRESCALER_TRIM_CONTROL_OFS = 8'h18;
  localparam logic [7:0] INTERRUPT_ENABLE_MASK_OFS = 8'h1C;
  localparam logic [7:0] RAW_IRQ_STATUS_OFS = 8'h20;
  localparam logic [7:0] MASKED_IRQ_STATUS_OFS = 8'h24;
  localparam logic [7:0] IRQ_CLEAR_OFS = 8'h28;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 15;
  localparam int DEL_LSB = 16;
  localparam int DEL_W = 10;
  localparam int RUN_BIT = 26;
  localparam int CAL_BIT = 0;
  localparam int CNT_BIT = 1;

  // ----------------------------------------
  // Reset values and counts
  // ----------------------------------------
  localparam logic [14:0] DIV_RESET = 15'h7FFF;
  localparam logic [9:0] DEL_RESET = 10'h000;
  localparam logic [9:0] TRIM_PERIOD = 10'h3FF;

  typedef struct packed {
    logic [14:0] tickDivider;
    logic [9:0] trimDeleteCount;
    logic calendarRunEnable;
    logic calendarIrqEnable;
    logic countdownIrqEnable;
    logic [1:0] rawIrq;
    logic [14:0] divCount;
    logic [9:0] trimPos;
    logic calTick;
    logic cntTick;
    logic irqOut;
    logic [31:0] rdData;
  } rtps_state_s;

endpackage

// File: src/rtps_prescaler.sv
/*
  One-hertz reference prescaler with pulse-deletion trim, lockable
  configuration, and clockwatch/countdown interrupt masking.
  Assumes clk is the slow clock and rst_n is the power-on reset.
  Raw interrupt events come from the calendar and countdown logic
  on the same clock.
*/
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module rtps_prescaler (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  // Interrupt events from calendar and countdown logic
  input wire logic calendarEvent,
  input wire logic countdownEvent,
  // Ticks, run flag and interrupt
  output logic calendarTick,
  output logic countdownTick,
  output logic calendarRun,
  output logic irq
);

  rtps_pkg::rtps_state_s st_ff;
  rtps_pkg::rtps_state_s nxt_st;

  logic [1:0] masked;
  logic deletePulse;
  logic tickNow;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    masked = st_ff.rawIrq & {st_ff.countdownIrqEnable, st_ff.calendarIrqEnable};

    // Deletions sit at the first positions of each trim period so the
    // correction repeats identically every period.
    deletePulse = (st_ff.trimPos < st_ff.trimDeleteCount);
    if (st_ff.trimPos == rtps_pkg::TRIM_PERIOD - 10'h001) begin
      nxt_st.trimPos = 10'h000;
    end else begin
      nxt_st.trimPos = st_ff.trimPos + 10'h001;
    end

    tickNow = 1'b0;
    if (!deletePulse) begin
      if (st_ff.divCount >= st_ff.tickDivider) begin
        nxt_st.divCount = 15'h0000;
        tickNow = 1'b1;
      end else begin
        nxt_st.divCount = st_ff.divCount + 15'h0001;
      end
    end

    if (st_ff.tickDivider == 15'h0000) begin
      nxt_st.cntTick = ~st_ff.cntTick;
      nxt_st.calTick = 1'b0;
    end else begin
      nxt_st.cntTick = tickNow;
      nxt_st.calTick = tickNow & st_ff.calendarRunEnable;
    end

    // Event set wins over a clear in the same cycle
    if (regWrite && regAddr == rtps_pkg::IRQ_CLEAR_OFS) begin
      nxt_st.rawIrq = st_ff.rawIrq & ~regWrData[1:0];
    end
    nxt_st.rawIrq = nxt_st.rawIrq | {countdownEvent, calendarEvent};

    if (regWrite) begin
      if (regAddr == rtps_pkg::PRESCALER_TRIM_CONTROL_OFS) begin
        if (!st_ff.calendarRunEnable) begin
          nxt_st.tickDivider = regWrData[rtps_pkg::DIV_LSB +: rtps_pkg::DIV_W];
          nxt_st.trimDeleteCount = regWrData[rtps_pkg::DEL_LSB +: rtps_pkg::DEL_W];
          nxt_st.calendarRunEnable = regWrData[rtps_pkg::RUN_BIT];
        end
      end else if (regAddr == rtps_pkg::INTERRUPT_ENABLE_MASK_OFS) begin
        nxt_st.calendarIrqEnable = regWrData[rtps_pkg::CAL_BIT];
        nxt_st.countdownIrqEnable = regWrData[rtps_pkg::CNT_BIT];
      end
    end

    nxt_st.irqOut = |(nxt_st.rawIrq &
      {nxt_st.countdownIrqEnable, nxt_st.calendarIrqEnable});

    nxt_st.rdData = 32'h0000_0000;
    if (regRead) begin
      if (regAddr == rtps_pkg::PRESCALER_TRIM_CONTROL_OFS) begin
        nxt_st.rdData[rtps_pkg::DIV_LSB +: rtps_pkg::DIV_W] = st_ff.tickDivider;
        nxt_st.rdData[rtps_pkg::DEL_LSB +: rtps_pkg::DEL_W] = st_ff.trimDeleteCount;
        nxt_st.rdData[rtps_pkg::RUN_BIT] = st_ff.calendarRunEnable;
      end else if (regAddr == rtps_pkg::INTERRUPT_ENABLE_MASK_OFS) begin
        nxt_st.rdData[rtps_pkg::CAL_BIT] = st_ff.calendarIrqEnable;
        nxt_st.rdData[rtps_pkg::CNT_BIT] = st_ff.countdownIrqEnable;
      end else if (regAddr == rtps_pkg::RAW_IRQ_STATUS_OFS) begin
        nxt_st.rdData[1:0] = st_ff.rawIrq;
      end else if (regAddr == rtps_pkg::MASKED_IRQ_STATUS_OFS) begin
        nxt_st.rdData[1:0] = masked;
      end else begin
        nxt_st.rdData = 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.tickDivider <= rtps_pkg::DIV_RESET;
      st_ff.trimDeleteCount <= rtps_pkg::DEL_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign regRdData = st_ff.rdData;
  assign calendarTick = st_ff.calTick;
  assign countdownTick = st_ff.cntTick;
  assign calendarRun = st_ff.calendarRunEnable;
  assign irq = st_ff.irqOut;

endmodule

`default_nettype wire

// File: verif/rtps_prescaler_properties.sv
/* Port assertions for the prescaler block.
   Assumes the bind below and one slow clock domain. */
`timescale 1ns/10ps
`default_nettype none
module rtps_prescaler_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdData,
  // Events and outputs
  input wire logic calendarEvent,
  input wire logic countdownEvent,
  input wire logic calendarTick,
  input wire logic countdownTick,
  input wire logic calendarRun,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic wClr = regWrite && regAddr == 8'h28;
  a_run_sticks: assert property (calendarRun |=> calendarRun) else $error("run dropped");
  a_run_starts: assert property (regWrite && regAddr == 8'h18 && regWrData[26] |=> calendarRun)
    else $error("run not set");
  a_run_gates: assert property (!calendarRun |-> !calendarTick) else $error("tick idle");
  a_tick_pulse: assert property (countdownTick |=> !countdownTick) else $error("long tick");
  a_irq_cause: assert property ($rose(irq) |-> $past(calendarEvent) || $past(countdownEvent)
    || $past(regWrite)) else $error("irq without cause");
  a_clear_drops: assert property (wClr && regWrData[1:0] == 2'h3 && !calendarEvent
    && !countdownEvent |=> !irq) else $error("clear failed");
  a_clear_zero: assert property (wClr && regWrData[1:0] == 2'h0 && irq |=> irq)
    else $error("zero cleared");
  a_mask_off: assert property (regWrite && regAddr == 8'h1C && regWrData[1:0] == 2'h0 |=> !irq)
    else $error("mask ignored");
endmodule
bind rtps_prescaler rtps_prescaler_properties rtps_prescaler_properties_i (.clk, .rst_n,
  .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .calendarEvent, .countdownEvent,
  .calendarTick, .countdownTick, .calendarRun, .irq);
`default_nettype wire

// File: verif/tb_top.sv
/* Bench for the prescaler: registers, trim counts, lock, interrupts.
   Assumes package and checker compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'h0, rst_n = 1'h0, regWrite = 1'h0, regRead = 1'h0;
  logic calendarEvent = 1'h0, countdownEvent = 1'h0;
  logic [7:0] regAddr = 8'h0;
  logic [31:0] regWrData = 32'h0, r = 32'h0496;
  logic [9:0] tv[4] = '{10'h0, 10'h3, 10'h3FF, 10'h1};
  wire logic [31:0] regRdData;
  wire logic calendarTick, countdownTick, calendarRun, irq;
  int num_errors = 0, checks = 0, a, b;
  always #12.5 clk = ~clk;
  rtps_prescaler rtps_prescaler_i (.clk, .rst_n, .regAddr, .regWrData, .regWrite, .regRead,
    .regRdData, .calendarEvent, .countdownEvent, .calendarTick, .countdownTick,
    .calendarRun, .irq);
  function automatic logic [31:0] lf(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Divider one over two trim periods: every kept pair of cycles gives a tick
  function automatic int tk(int t);
    return 1023 - t;
  endfunction
  task chk(logic [31:0] g, logic [31:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(logic [7:0] ad, logic [31:0] d);
    @(posedge clk);
    {regWrite, regAddr, regWrData} <= {1'h1, ad, d};
    @(posedge clk);
    regWrite <= 1'h0;
  endtask
  task rd(logic [7:0] ad, logic [31:0] e);
    @(posedge clk);
    {regRead, regAddr} <= {1'h1, ad};
    @(posedge clk);
    regRead <= 1'h0;
    @(negedge clk);
    chk(regRdData, e);
  endtask
  task ev(logic c, logic t);
    @(posedge clk);
    {calendarEvent, countdownEvent} <= {c, t};
    @(posedge clk);
    {calendarEvent, countdownEvent} <= 2'h0;
  endtask
  task ci(logic e);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task cnt(int n);
    a = 0;
    b = 0;
    repeat (n) @(posedge clk) begin
      a += calendarTick;
      b += countdownTick;
    end
  endtask
  task tally_and_finish;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    rd(8'h18, 32'h0000_7FFF);
    rd(8'h1C, 32'h0);
    r = lf(r);
    tv[3] = r[9:0];
    foreach (tv[i]) begin
      wr(8'h18, {6'h0, tv[i], 16'h0001});
      repeat (4) @(posedge clk);
      cnt(2046);
      chk(b, tk(tv[i]));
    end
    wr(8'h1C, {r[31:2], 2'h1});
    ev(1'h0, 1'h1);
    ci(1'h0);
    ev(1'h1, 1'h0);
    ci(1'h1);
    rd(8'h24, 32'h1);
    rd(8'h20, 32'h3);
    wr(8'h28, 32'h1);
    ci(1'h0);
    wr(8'h1C, 32'h2);
    ci(1'h1);
    wr(8'h28, 32'h0);
    ci(1'h1);
    wr(8'h28, 32'h3);
    ci(1'h0);
    rd(8'h40, 32'h0);
    ev(1'h1, 1'h1);
    wr(8'h1C, 32'h0);
    ci(1'h0);
    wr(8'h18, 32'h0400_0000);
    repeat (4) @(posedge clk);
    cnt(20);
    chk(a, 0);
    chk(b, 10);
    wr(8'h18, 32'h0000_0001);
    rd(8'h18, 32'h0400_0000);
    chk({31'h0, calendarRun}, 32'h1);
    tally_and_finish;
  end
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
